// ===== hw/cta_channel.v
// Channel trap, assembly load/store and set-mode command interpreter
// Behaviour
// - Trap command enters wait, requests trap if enabled
// - Trap address, or indirect Y, loads address counter
// - Trap decode holds interrupt request reset
// - Blocked interrupts saved, raised on resume
// - Enabled channel drives remote trap to lower
// - Priority won sets trigger, demand at 8
// - Trap signal returns trap address gate on the next clock
// - Late store-trap resets sync and priority triggers
// - Start during pending trap is dropped, not queued
// - Disabled trap acts as wait; start resumes
// - Load assembly replaces register from location Y
// - Fetch loads registers at 7, decode at 0
// - Load gate clears at the 7-time data strobe
// - Load execute resets assembly, sets load gate, write status, request
// - Data cycle waits for priority grant
// - Load cycle: address out, data strobed at 7
// - Store gate, read status, request, reset data
// - Store: address out, data loaded, store control
// - Data written to store, channel returns to idle
// - Set mode bits 29-32 set mode triggers
// - Bits 33-35 too; resets clear all triggers
`timescale 1ns/1ps
module cta_channel #(
  parameter AW      = 4,
  parameter CHAN_ID = 3'h0
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        srst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Multiplexor side
  input  wire        higher_trap_req,
  input  wire        data_cycle_grant,
  input  wire        chan_trap,
  input  wire        str_late,
  input  wire        int_cond,
  output reg         remote_trap_out,
  output reg         trap_demand,
  output reg         trap_addr_gate,
  output reg         store_control,
  output reg         data_cycle_req,
  output reg         int_request,
  output reg  [14:0] mem_addr
);
`include "cta_regs.vh"
  localparam S_IDLE  = 3'h0;
  localparam S_FETCH = 3'h1;
  localparam S_CCC   = 3'h2;
  localparam S_CMMD  = 3'h3;
  localparam S_DATA  = 3'h4;
  localparam S_WAIT  = 3'h5;

  wire [3:0] tp;
  wire       cyc_go;
  cta_cycle_timer u_tim (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .tpulse    (tp),
    .cyc_start (cyc_go)
  );

  reg  [2:0]  state;
  reg  [31:0] cmd_word;
  reg  [3:0]  op_reg;
  reg         op_active;
  reg  [14:0] addr_cnt;
  reg  [17:0] word_cnt;
  reg  [35:0] asm_reg;
  reg  [35:0] data_reg;
  reg  [6:0]  mode_trig;
  reg         trap_en;
  reg         wait_st;
  reg         load_gate;
  reg         store_gate;
  reg         write_st;
  reg         read_st;
  reg         trap_sync;
  reg         trap_pri;
  reg         int_block;
  reg         int_pend;
  reg         start_pend;
  reg         fetch_ld;
  reg         fetch_go;
  reg         mem_we;
  reg  [35:0] mem_wdata;
  wire [35:0] mem_rdata;
  reg  [AW-1:0] mem_raddr;

  cta_word_store #(.AW(AW), .DW(36)) u_mem (
    .sys_clk (sys_clk),
    .we      (mem_we),
    .waddr   (addr_cnt[AW-1:0]),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr   = wb_req & wb_we_i;
  wire is_trap = (op_reg == `CTA_OP_TRAP_WAIT);
  wire indirect = cmd_word[`CTA_CMD_IND_BIT];
  wire [14:0] cmd_adr = cmd_word[`CTA_CMD_ADR_LSB+14:`CTA_CMD_ADR_LSB];
  wire trap_busy = trap_sync | trap_pri;
  // Busy means a command in flight; a parked channel reads as not busy
  wire chan_busy = (state != S_IDLE) && (state != S_WAIT);
  wire [14:0] trap_loc = `CTA_TRAP_BASE + {11'h000, CHAN_ID, 1'b0};

  // Wishbone: one-cycle ack, unmapped reads return zero
  always @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `CTA_OFS_STATUS) begin
          wb_dat_o <= {24'h000000, trap_en, read_st, write_st, int_pend,
                       int_block, trap_busy, chan_busy, wait_st};
        end else if (wb_adr_i == `CTA_OFS_ASSEMBLY) begin
          wb_dat_o <= asm_reg[31:0];
        end else if (wb_adr_i == `CTA_OFS_MODE) begin
          wb_dat_o <= {25'h0000000, mode_trig};
        end else if (wb_adr_i == `CTA_OFS_ADDR) begin
          wb_dat_o <= {17'h00000, addr_cnt};
        end else if (wb_adr_i == `CTA_OFS_CMD) begin
          wb_dat_o <= cmd_word;
        end else if (wb_adr_i == `CTA_OFS_TRAPLOC) begin
          wb_dat_o <= {17'h00000, trap_loc};
        end
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      state          <= S_WAIT;
      cmd_word       <= 32'h00000000;
      op_reg         <= 4'h0;
      op_active      <= 1'b0;
      addr_cnt       <= 15'h0000;
      word_cnt       <= 18'h00000;
      asm_reg        <= 36'h000000000;
      data_reg       <= 36'h000000000;
      mode_trig      <= `CTA_MODE_RESET;
      trap_en        <= 1'b0;
      wait_st        <= 1'b1;
      load_gate      <= 1'b0;
      store_gate     <= 1'b0;
      write_st       <= 1'b0;
      read_st        <= 1'b0;
      trap_sync      <= 1'b0;
      trap_pri       <= 1'b0;
      int_block      <= 1'b0;
      int_pend       <= 1'b0;
      start_pend     <= 1'b0;
      fetch_ld       <= 1'b0;
      fetch_go       <= 1'b0;
      mem_we         <= 1'b0;
      mem_wdata      <= 36'h000000000;
      mem_raddr      <= {AW{1'b0}};
      remote_trap_out <= 1'b0;
      trap_demand    <= 1'b0;
      trap_addr_gate <= 1'b0;
      store_control  <= 1'b0;
      data_cycle_req <= 1'b0;
      int_request    <= 1'b0;
      mem_addr       <= 15'h0000;
    end else begin
      mem_we        <= 1'b0;
      store_control <= 1'b0;
      // Software writes: command, trap enable, start
      if (wb_wr && wb_adr_i == `CTA_OFS_CMD && wb_sel_i == 4'hf) begin
        cmd_word <= wb_dat_i;
        fetch_go <= 1'b1;
      end else if (wb_wr && wb_adr_i == `CTA_OFS_STATUS && wb_sel_i[0]) begin
        trap_en <= wb_dat_i[`CTA_ST_TRAP_EN];
      end else if (wb_wr && wb_adr_i == `CTA_OFS_ASSEMBLY
                   && wb_sel_i == 4'hf) begin
        mem_wdata <= {4'h0, wb_dat_i};
        mem_we    <= 1'b1;
      end
      if (wb_wr && wb_adr_i == `CTA_OFS_START) begin
        if (trap_busy) begin
          // Dropped, not queued, so it cannot resume the channel later
          start_pend <= 1'b0;
        end else begin
          start_pend <= 1'b1;
        end
      end
      // Saved interrupt condition; set wins over clear
      if (int_cond) begin
        int_pend <= 1'b1;
      end else if (!int_block && int_pend && !int_request) begin
        int_pend <= 1'b0;
      end
      // Interrupt request held reset while trap command blocks
      if (int_block) begin
        int_request <= 1'b0;
      end else if (int_pend) begin
        int_request <= 1'b1;
      end else begin
        int_request <= 1'b0;
      end
      // Trap priority: enabled request drives lower channels
      remote_trap_out <= trap_sync & trap_en;
      if (trap_sync && trap_en && !higher_trap_req
          && tp == `CTA_T_DEMAND) begin
        trap_pri    <= 1'b1;
        trap_demand <= 1'b1;
      end
      if (chan_trap && trap_pri) begin
        trap_addr_gate <= 1'b1;
        trap_demand    <= 1'b0;
      end
      if (str_late) begin
        trap_sync      <= 1'b0;
        trap_pri       <= 1'b0;
        trap_addr_gate <= 1'b0;
        trap_demand    <= 1'b0;
      end
      case (state)
        S_WAIT: begin
          // Start, once the trap is served, clears wait and blocking, then resumes
          if (start_pend && !trap_busy) begin
            start_pend <= 1'b0;
            wait_st    <= 1'b0;
            int_block  <= 1'b0;
            // Re-running the parked trap command would trap again
            state      <= fetch_go ? S_FETCH : S_IDLE;
            fetch_go   <= 1'b0;
          end else if (fetch_go) begin
            fetch_go <= 1'b0;
            wait_st  <= 1'b0;
            state    <= S_FETCH;
          end
        end
        S_IDLE: begin
          if (fetch_go) begin
            fetch_go <= 1'b0;
            state    <= S_FETCH;
          end
        end
        S_FETCH: begin
          // Decode only after a 7-time load in this fetch; a mid-cycle
          // entry would otherwise decode the previous operation
          mem_raddr <= cmd_adr[AW-1:0];
          if (tp == `CTA_T_LOAD) begin
            op_reg   <= cmd_word[3:0];
            word_cnt <= {14'h0000, cmd_word[11:8]};
            addr_cnt <= cmd_adr;
            fetch_ld <= 1'b1;
          end else if (tp == `CTA_T_ZERO && cyc_go && fetch_ld) begin
            fetch_ld  <= 1'b0;
            op_active <= 1'b1;
            state     <= S_CCC;
          end
        end
        S_CCC: begin
          if (op_active && is_trap) begin
            int_block <= 1'b1;
          end
          if (indirect && tp == `CTA_T_LOAD) begin
            addr_cnt <= mem_rdata[14:0];
            word_cnt <= mem_rdata[35:18];
          end
          if (cyc_go) begin
            state <= S_CMMD;
          end
        end
        S_CMMD: begin
          if (op_reg == `CTA_OP_TRAP_WAIT || op_reg == `CTA_OP_WAIT_XFER) begin
            wait_st   <= 1'b1;
            trap_sync <= is_trap & trap_en;
            op_active <= 1'b0;
            state     <= S_WAIT;
          end else if (op_reg == `CTA_OP_LOAD_ASM) begin
            load_gate      <= 1'b1;
            asm_reg        <= 36'h000000000;
            write_st       <= 1'b1;
            data_cycle_req <= 1'b1;
            mem_raddr      <= addr_cnt[AW-1:0];
            state          <= S_DATA;
          end else if (op_reg == `CTA_OP_STORE_ASM) begin
            store_gate     <= 1'b1;
            read_st        <= 1'b1;
            data_cycle_req <= 1'b1;
            data_reg       <= 36'h000000000;
            state          <= S_DATA;
          end else if (op_reg == `CTA_OP_SET_MODE) begin
            mode_trig <= addr_cnt[6:0];
            op_active <= 1'b0;
            state     <= S_IDLE;
          end else begin
            op_active <= 1'b0;
            state     <= S_IDLE;
          end
        end
        S_DATA: begin
          // Data cycle runs only once priority is granted
          if (data_cycle_req && data_cycle_grant) begin
            data_cycle_req <= 1'b0;
            mem_addr       <= addr_cnt;
            if (store_gate) begin
              data_reg      <= asm_reg;
              store_control <= 1'b1;
            end
          end else if (!data_cycle_req && load_gate) begin
            if (tp == `CTA_T_EARLY) begin
              data_reg <= 36'h000000000;
            end else if (tp == `CTA_T_STROBE) begin
              data_reg <= mem_rdata;
              asm_reg  <= mem_rdata;
              load_gate <= 1'b0;
              write_st  <= 1'b0;
              op_active <= 1'b0;
              state     <= S_IDLE;
            end
          end else if (!data_cycle_req && store_gate) begin
            mem_wdata  <= data_reg;
            mem_we     <= 1'b1;
            store_gate <= 1'b0;
            read_st    <= 1'b0;
            op_active  <= 1'b0;
            state      <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // cta_channel

// ===== hw/cta_cycle_timer.v
// Machine cycle time-pulse generator
`timescale 1ns/1ps
module cta_cycle_timer (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       srst,
  // Time pulse index and cycle start strobe
  output reg  [3:0] tpulse,
  output reg        cyc_start
);
`include "cta_regs.vh"
  always @(posedge sys_clk) begin
    if (srst) begin
      tpulse    <= 4'h0;
      cyc_start <= 1'b0;
    end else begin
      if (tpulse == `CTA_CYC_LEN - 4'h1) begin
        tpulse    <= 4'h0;
        cyc_start <= 1'b1;
      end else begin
        tpulse    <= tpulse + 4'h1;
        cyc_start <= 1'b0;
      end
    end
  end
endmodule // cta_cycle_timer

// ===== hw/cta_regs.vh
// Register offsets, field positions and timing counts for the channel block
`ifndef CTA_REGS_VH
`define CTA_REGS_VH
// Wishbone word offsets (byte addresses)
`define CTA_OFS_CMD      8'h00
`define CTA_OFS_STATUS   8'h04
`define CTA_OFS_ASSEMBLY 8'h08
`define CTA_OFS_MODE     8'h0c
`define CTA_OFS_ADDR     8'h10
`define CTA_OFS_START    8'h14
`define CTA_OFS_TRAPLOC  8'h18
// Command codes in CMD[3:0]
`define CTA_OP_TRAP_WAIT 4'h1
`define CTA_OP_WAIT_XFER 4'h2
`define CTA_OP_LOAD_ASM  4'h3
`define CTA_OP_STORE_ASM 4'h4
`define CTA_OP_SET_MODE  4'h5
// CMD fields: bit 4 indirect, address in bits 30:16, mode bits 22:16
`define CTA_CMD_IND_BIT  4
`define CTA_CMD_ADR_LSB  16
// Status bits
`define CTA_ST_WAIT      0
`define CTA_ST_BUSY      1
`define CTA_ST_TRAP_REQ  2
`define CTA_ST_INT_BLOCK 3
`define CTA_ST_INT_PEND  4
`define CTA_ST_WRITE     5
`define CTA_ST_READ      6
`define CTA_ST_TRAP_EN   7
// Timing marks within a twelve-pulse machine cycle
`define CTA_CYC_LEN      4'hc
`define CTA_T_LOAD       4'h7
`define CTA_T_ZERO       4'h0
`define CTA_T_DEMAND     4'h8
`define CTA_T_EARLY      4'h2
`define CTA_T_STROBE     4'h7
`define CTA_T_LATE       4'ha
// Trap location base for channel 0 (octal 12), step of two
`define CTA_TRAP_BASE    15'h000a
`define CTA_MODE_RESET   7'h00
`endif

// ===== hw/cta_word_store.v
// Small core-storage model word memory with registered read data
`timescale 1ns/1ps
module cta_word_store #(
  parameter AW = 4,
  parameter DW = 36
) (
  // Clock
  input  wire          sys_clk,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // Read port
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // cta_word_store

// ===== test/cta_channel_sva.sv
// Port checker for the channel command block
`timescale 1ns/1ps
module cta_channel_sva (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Bus and multiplexor side
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire higher_trap_req,
  input wire data_cycle_grant,
  input wire chan_trap,
  input wire str_late,
  input wire remote_trap_out,
  input wire trap_demand,
  input wire trap_addr_gate,
  input wire store_control,
  input wire data_cycle_req,
  input wire int_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  AST_REMOTE: assert property (
    trap_demand |-> remote_trap_out)
    else $error("demand without remote trap");
  AST_PRIO: assert property (
    $rose(trap_demand) |-> !$past(higher_trap_req))
    else $error("demand beside higher request");
  AST_DROP: assert property (
    trap_demand && chan_trap |-> ##[1:2] !trap_demand)
    else $error("demand held after trap");
  AST_GATE: assert property (
    chan_trap && trap_demand |-> ##[1:2] trap_addr_gate)
    else $error("trap gate not returned");
  AST_LATE: assert property (
    str_late |-> ##[1:2] (!trap_addr_gate && !trap_demand))
    else $error("trap triggers not reset");
  AST_BLOCK: assert property (
    remote_trap_out |-> !int_request)
    else $error("interrupt while blocked");
  AST_GRANT: assert property (
    data_cycle_req && data_cycle_grant |-> ##[1:2] !data_cycle_req)
    else $error("data request held after grant");
  AST_STORE: assert property (
    $rose(store_control) |-> $past(data_cycle_grant))
    else $error("store control without grant");
endmodule // cta_channel_sva

bind cta_channel cta_channel_sva i_chk (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .higher_trap_req, .data_cycle_grant, .chan_trap, .str_late,
  .remote_trap_out, .trap_demand, .trap_addr_gate, .store_control,
  .data_cycle_req, .int_request);

// ===== test/cta_host_model.sv
// Host computer model: data cycle grant and trap service
`timescale 1ns/1ps
module cta_host_model (
  // Clock and reset
  input  wire sys_clk,
  input  wire srst,
  // Channel requests
  input  wire trap_demand,
  input  wire data_cycle_req,
  // Answers
  output reg  data_cycle_grant,
  output reg  chan_trap,
  output reg  str_late
);
  reg [3:0] cnt;
  reg [3:0] tcnt;
  reg       slow;
  always @(posedge sys_clk) begin
    if (srst) begin
      {data_cycle_grant, chan_trap, str_late, slow} <= 4'h0;
      cnt <= 4'h0;
      tcnt <= 4'h0;
    end else begin
      str_late <= 1'b0;
      // Alternate prompt and slow grants
      if (data_cycle_req && !data_cycle_grant) begin
        cnt <= cnt + 4'h1;
        if (cnt == (slow ? 4'h6 : 4'h0)) begin
          data_cycle_grant <= 1'b1;
          cnt <= 4'h0;
          slow <= !slow;
        end
      end else if (!data_cycle_req)
        data_cycle_grant <= 1'b0;
      // Trap trigger some pulses later, then store-and-trap
      if (trap_demand || chan_trap) begin
        tcnt <= tcnt + 4'h1;
        if (tcnt == 4'h5)
          chan_trap <= 1'b1;
        if (tcnt == 4'hc) begin
          str_late <= 1'b1;
          chan_trap <= 1'b0;
          tcnt <= 4'h0;
        end
      end
    end
  end
endmodule // cta_host_model

// ===== test/tb_top.sv
// Self-checking bench for the channel command block
`timescale 1ns/1ps
`include "cta_regs.vh"
module tb_top;
  reg         sys_clk;
  reg         srst;
  reg         wb_cyc_i;
  reg         wb_stb_i;
  reg         wb_we_i;
  reg  [7:0]  wb_adr_i;
  reg  [31:0] wb_dat_i;
  reg         higher_trap_req;
  reg         int_cond;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  wire        data_cycle_grant;
  wire        chan_trap;
  wire        str_late;
  wire        remote_trap_out;
  wire        trap_demand;
  wire        trap_addr_gate;
  wire        store_control;
  wire        data_cycle_req;
  wire        int_request;
  wire [14:0] mem_addr;
  reg  [31:0] q;
  reg  [14:0] sadr;
  integer     failures;
  integer     compares;
  integer     i;
  cta_channel #(.AW(4), .CHAN_ID(3'h0)) i_dut (.sys_clk, .srst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .higher_trap_req, .data_cycle_grant, .chan_trap, .str_late,
    .int_cond, .remote_trap_out, .trap_demand, .trap_addr_gate,
    .store_control, .data_cycle_req, .int_request, .mem_addr);
  cta_host_model i_host (.sys_clk, .srst, .trap_demand, .data_cycle_req,
    .data_cycle_grant, .chan_trap, .str_late);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Address seen when store control fires
  always @(posedge sys_clk)
    if (store_control === 1'b1)
      sadr <= mem_addr;
  // Waits for ack as long as it takes; only the watchdog ends a hang
  task automatic wb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
        @(posedge sys_clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Issue a command, then poll busy; grants come from the host model
  task automatic run(input [14:0] a, input [3:0] op);
    integer n;
    begin
      wb(8'h00, 1'b1, {1'b0, a, 12'h000, op});
      repeat (4) @(posedge sys_clk);
      n = 0;
      do begin
        wb(8'h04, 1'b0, 32'h0);
        n = n + 1;
      end while (q[1] !== 1'b0 && n < 80);
      if (q[1] !== 1'b0)
        failures = failures + 1;
    end
  endtask
  task test_done;
    begin
      if (failures == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    srst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    higher_trap_req = 1'b0;
    int_cond = 1'b0;
    failures = 0;
    compares = 0;
    sadr = 15'h0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    wb(8'h04, 1'b0, 32'h0);
    chk("status", 32'h1, q);
    wb(8'h0c, 1'b0, 32'h0);
    chk("mode", 32'h0, q);
    wb(8'h1c, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    for (i = 0; i < 2; i = i + 1) begin
      run(i ? 15'h2a : 15'h55, 4'h5);
      wb(8'h0c, 1'b0, 32'h0);
      chk("mode", i ? 32'h2a : 32'h55, q);
    end
    // Assembly load, store, reload; a stale word must not leak through
    run(15'h3, 4'h3);
    wb(8'h08, 1'b1, 32'hcafe1234);
    run(15'h3, 4'h3);
    wb(8'h08, 1'b0, 32'h0);
    chk("asm load", 32'hcafe1234, q);
    run(15'h5, 4'h4);
    wb(8'h08, 1'b0, 32'h0);
    chk("asm kept", 32'hcafe1234, q);
    chk("store adr", 32'h5, {17'h0, sadr});
    run(15'h6, 4'h3);
    wb(8'h08, 1'b1, 32'h0);
    run(15'h6, 4'h3);
    wb(8'h08, 1'b0, 32'h0);
    chk("asm new", 32'h0, q);
    run(15'h5, 4'h3);
    wb(8'h08, 1'b0, 32'h0);
    chk("stored", 32'hcafe1234, q);
    // Enabled trap held off by a higher channel
    higher_trap_req <= 1'b1;
    wb(8'h04, 1'b1, 32'h80);
    run(15'h7, 4'h1);
    wb(8'h04, 1'b0, 32'h0);
    chk("pending", 32'h1, {31'h0, q[2]});
    chk("held off", 32'h0, {31'h0, trap_demand});
    chk("remote", 32'h1, {31'h0, remote_trap_out});
    @(posedge sys_clk) int_cond <= 1'b1;
    @(posedge sys_clk) int_cond <= 1'b0;
    wb(8'h14, 1'b1, 32'h0);
    wb(8'h04, 1'b0, 32'h0);
    chk("start no-op", 32'h5, {29'h0, q[2:0]});
    higher_trap_req <= 1'b0;
    i = 0;
    while (str_late !== 1'b1 && i < 300) begin
      @(posedge sys_clk);
      i = i + 1;
    end
    chk("trap served", 32'h1, {31'h0, str_late});
    repeat (3) @(posedge sys_clk);
    chk("gate", 32'h0, {31'h0, trap_addr_gate});
    wb(8'h04, 1'b0, 32'h0);
    chk("wait+block", 32'h9, {28'h0, q[3:0]});
    chk("int held", 32'h0, {31'h0, int_request});
    wb(8'h10, 1'b0, 32'h0);
    chk("restart adr", 32'h7, q);
    wb(8'h18, 1'b0, 32'h0);
    chk("trap loc", `CTA_TRAP_BASE, q);
    wb(8'h14, 1'b1, 32'h0);
    i = 0;
    while (int_request !== 1'b1 && i < 100) begin
      @(posedge sys_clk);
      i = i + 1;
    end
    chk("int saved", 32'h1, {31'h0, int_request});
    wb(8'h04, 1'b0, 32'h0);
    chk("resumed", 32'h0, {31'h0, q[0]});
    // Trap command with traps disabled acts as a plain wait
    wb(8'h04, 1'b1, 32'h0);
    run(15'h9, 4'h1);
    wb(8'h04, 1'b0, 32'h0);
    chk("plain wait", 32'h1, {29'h0, q[2:0]});
    wb(8'h10, 1'b0, 32'h0);
    chk("wait adr", 32'h9, q);
    test_done;
  end
  initial begin
    #400000;
    failures = failures + 1;
    test_done;
  end
endmodule // tb_top
